// ===== verilog/dpll_profile_consts.vh
`ifndef DPLL_PROFILE_CONSTS_VH
`define DPLL_PROFILE_CONSTS_VH

// Register indices; byte address on the bus is four times the index
`define IDX_VALID_LO 12'h70b
`define IDX_VALID_HI 12'h70c
`define IDX_SPARE 12'h70d
`define IDX_MARGIN 12'h70e
`define IDX_BW_LO 12'h70f
`define IDX_BW_MID 12'h710
`define IDX_BW_TOP 12'h711
`define IDX_RDIV_LO 12'h712
`define IDX_RDIV_MID 12'h713
`define IDX_RDIV_TOP 12'h714
`define IDX_NINT_LO 12'h715
`define IDX_NINT_MID 12'h716
`define IDX_NINT_TOP 12'h717
`define IDX_FRAC_LO 12'h718
`define IDX_FRAC_MID 12'h719
`define IDX_FRAC_TOP 12'h71a
`define IDX_MOD_LO 12'h71b
`define IDX_MOD_MID 12'h71c
`define IDX_MOD_TOP 12'h71d
`define IDX_STATUS 12'h730

// Reset values
`define RST_VALID_LO 8'h0a
`define RST_VALID_HI 8'h00
`define RST_MARGIN 8'h00
`define RST_BW_LO 8'hf4
`define RST_BW_MID 8'h01
`define RST_BW_TOP 8'h00
`define RST_RDIV_LO 8'hc5
`define RST_RDIV_MID 8'h00
`define RST_RDIV_TOP 8'h00
`define RST_NINT_LO 8'h6b
`define RST_NINT_MID 8'h07
`define RST_NINT_TOP 8'h00
`define RST_FRAC_LO 8'h04
`define RST_FRAC_MID 8'h00
`define RST_FRAC_TOP 8'h00
`define RST_MOD_LO 8'h05
`define RST_MOD_MID 8'h00
`define RST_MOD_TOP 8'h00

// Field positions
`define MARGIN_BIT 0
`define BW_TOP_BIT 0
`define RDIV_TOP_MSB 3
`define HALVER_BIT 4
`define NINT_TOP_BIT 0
`define FRAC_TOP_MSB 6
`define STAT_VALID_BIT 0
`define STAT_HALVER_BIT 1

// Timing
`define MS_NS 1000000
`define CLK_PERIOD_NS 50
`define CYCLES_PER_MS (`MS_NS / `CLK_PERIOD_NS)

`endif

// ===== verilog/dpll_reference_profile_regs.v
// What this block does
// - Reference valid after validation time elapses, milliseconds
// - Margin select bit picks normal or high filter
// - Loop bandwidth from 17-bit tenth-hertz factor
// - Reference divider divides by value plus one
// - Halver bit inserts reference divide-by-two
// - Feedback integer divides by value plus one
// - Fractional numerator is 23-bit field
// - Fractional denominator from separate 23-bit modulus
`timescale 1ns/100ps
`include "dpll_profile_consts.vh"

module dpll_reference_profile_regs #(
  parameter CYCLES_PER_MS = `CYCLES_PER_MS
) (
  input wire clk,
  input wire sys_rst,
  input wire clk_en,
  input wire [13:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg waitrequest,
  input wire reference_present,
  input wire first_reference_input,
  input wire feedback_input,
  output reg reference_valid,
  output reg high_margin_filter,
  output reg [16:0] bandwidth_scale_factor,
  output reg [20:0] reference_divide_ratio,
  output reg reference_halver_enable,
  output reg [17:0] feedback_integer_ratio,
  output reg [22:0] feedback_numerator,
  output reg [22:0] feedback_modulus,
  output reg phase_detector_tick,
  output reg feedback_tick
);

  reg [7:0] valid_lo_reg;
  reg [7:0] valid_hi_reg;
  reg margin_reg;
  reg [7:0] bw_lo_reg;
  reg [7:0] bw_mid_reg;
  reg bw_top_reg;
  reg [7:0] rdiv_lo_reg;
  reg [7:0] rdiv_mid_reg;
  reg [3:0] rdiv_top_reg;
  reg halver_reg;
  reg [7:0] nint_lo_reg;
  reg [7:0] nint_mid_reg;
  reg nint_top_reg;
  reg [7:0] frac_lo_reg;
  reg [7:0] frac_mid_reg;
  reg [6:0] frac_top_reg;
  reg [7:0] mod_lo_reg;
  reg [7:0] mod_mid_reg;
  reg [6:0] mod_top_reg;

  // Whole reset bytes as constants; narrow fields take only their own bits,
  // so the reset branch never truncates a byte into a short register
  localparam [7:0] MARGIN_RESET = `RST_MARGIN;
  localparam [7:0] BW_TOP_RESET = `RST_BW_TOP;
  localparam [7:0] RDIV_TOP_RESET = `RST_RDIV_TOP;
  localparam [7:0] NINT_TOP_RESET = `RST_NINT_TOP;
  localparam [7:0] FRAC_TOP_RESET = `RST_FRAC_TOP;
  localparam [7:0] MOD_TOP_RESET = `RST_MOD_TOP;

  wire [11:0] index = address[13:2];
  wire wr_en = byteenable[0] & ~(|address[1:0]);
  wire [7:0] wbyte = writedata[7:0];
  wire accept = (read | write) & waitrequest;

  // Status byte: read-only view of the monitor and the halver
  reg [7:0] status_byte;
  always @* begin
    status_byte = 8'h00;
    status_byte[`STAT_VALID_BIT] = reference_valid;
    status_byte[`STAT_HALVER_BIT] = reference_halver_enable;
  end

  // Byte view of each register; reserved bits and unmapped indices read zero
  function [7:0] reg_byte;
    input [11:0] idx;
    begin
      case (idx)
        `IDX_VALID_LO: reg_byte = valid_lo_reg;
        `IDX_VALID_HI: reg_byte = valid_hi_reg;
        `IDX_MARGIN: reg_byte = {7'h00, margin_reg};
        `IDX_BW_LO: reg_byte = bw_lo_reg;
        `IDX_BW_MID: reg_byte = bw_mid_reg;
        `IDX_BW_TOP: reg_byte = {7'h00, bw_top_reg};
        `IDX_RDIV_LO: reg_byte = rdiv_lo_reg;
        `IDX_RDIV_MID: reg_byte = rdiv_mid_reg;
        `IDX_RDIV_TOP: reg_byte = {3'h0, halver_reg, rdiv_top_reg};
        `IDX_NINT_LO: reg_byte = nint_lo_reg;
        `IDX_NINT_MID: reg_byte = nint_mid_reg;
        `IDX_NINT_TOP: reg_byte = {7'h00, nint_top_reg};
        `IDX_FRAC_LO: reg_byte = frac_lo_reg;
        `IDX_FRAC_MID: reg_byte = frac_mid_reg;
        `IDX_FRAC_TOP: reg_byte = {1'b0, frac_top_reg};
        `IDX_MOD_LO: reg_byte = mod_lo_reg;
        `IDX_MOD_MID: reg_byte = mod_mid_reg;
        `IDX_MOD_TOP: reg_byte = {1'b0, mod_top_reg};
        `IDX_STATUS: reg_byte = status_byte;
        default: reg_byte = 8'h00;
      endcase
    end
  endfunction

  // Bus slave: request taken while waitrequest is high, answered one cycle later
  // With clock enable low the request simply waits, so the master sees a stall
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end else if (clk_en) begin
      if (accept) begin
        waitrequest <= 1'b0;
        readdata <= read ? {24'h000000, reg_byte(index)} : 32'h00000000;
      end else begin
        waitrequest <= 1'b1;
      end
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      valid_lo_reg <= `RST_VALID_LO;
      valid_hi_reg <= `RST_VALID_HI;
      margin_reg <= MARGIN_RESET[`MARGIN_BIT];
      bw_lo_reg <= `RST_BW_LO;
      bw_mid_reg <= `RST_BW_MID;
      bw_top_reg <= BW_TOP_RESET[`BW_TOP_BIT];
      rdiv_lo_reg <= `RST_RDIV_LO;
      rdiv_mid_reg <= `RST_RDIV_MID;
      rdiv_top_reg <= RDIV_TOP_RESET[`RDIV_TOP_MSB:0];
      halver_reg <= RDIV_TOP_RESET[`HALVER_BIT];
      nint_lo_reg <= `RST_NINT_LO;
      nint_mid_reg <= `RST_NINT_MID;
      nint_top_reg <= NINT_TOP_RESET[`NINT_TOP_BIT];
      frac_lo_reg <= `RST_FRAC_LO;
      frac_mid_reg <= `RST_FRAC_MID;
      frac_top_reg <= FRAC_TOP_RESET[`FRAC_TOP_MSB:0];
      mod_lo_reg <= `RST_MOD_LO;
      mod_mid_reg <= `RST_MOD_MID;
      mod_top_reg <= MOD_TOP_RESET[`FRAC_TOP_MSB:0];
    end else if (clk_en && accept && write && wr_en) begin
      // Spare byte and status have no storage, so writes there vanish
      // Bytes land one at a time; a divider runs on a part-written value meanwhile
      case (index)
        `IDX_VALID_LO: valid_lo_reg <= wbyte;
        `IDX_VALID_HI: valid_hi_reg <= wbyte;
        `IDX_MARGIN: margin_reg <= wbyte[`MARGIN_BIT];
        `IDX_BW_LO: bw_lo_reg <= wbyte;
        `IDX_BW_MID: bw_mid_reg <= wbyte;
        `IDX_BW_TOP: bw_top_reg <= wbyte[`BW_TOP_BIT];
        `IDX_RDIV_LO: rdiv_lo_reg <= wbyte;
        `IDX_RDIV_MID: rdiv_mid_reg <= wbyte;
        `IDX_RDIV_TOP: begin
          rdiv_top_reg <= wbyte[`RDIV_TOP_MSB:0];
          halver_reg <= wbyte[`HALVER_BIT];
        end
        `IDX_NINT_LO: nint_lo_reg <= wbyte;
        `IDX_NINT_MID: nint_mid_reg <= wbyte;
        `IDX_NINT_TOP: nint_top_reg <= wbyte[`NINT_TOP_BIT];
        `IDX_FRAC_LO: frac_lo_reg <= wbyte;
        `IDX_FRAC_MID: frac_mid_reg <= wbyte;
        `IDX_FRAC_TOP: frac_top_reg <= wbyte[`FRAC_TOP_MSB:0];
        `IDX_MOD_LO: mod_lo_reg <= wbyte;
        `IDX_MOD_MID: mod_mid_reg <= wbyte;
        `IDX_MOD_TOP: mod_top_reg <= wbyte[`FRAC_TOP_MSB:0];
        default: valid_lo_reg <= valid_lo_reg;
      endcase
    end
  end

  // Divider ratios are the programmed value plus one
  function [20:0] plus_one;
    input [19:0] value;
    begin
      plus_one = {1'b0, value} + 21'h000001;
    end
  endfunction

  // Assembled fields, lowest address least significant
  wire [15:0] valid_time = {valid_hi_reg, valid_lo_reg};
  wire [19:0] rdiv_value = {rdiv_top_reg, rdiv_mid_reg, rdiv_lo_reg};
  wire [16:0] nint_value = {nint_top_reg, nint_mid_reg, nint_lo_reg};
  wire [22:0] frac_value = {frac_top_reg, frac_mid_reg, frac_lo_reg};
  wire [22:0] mod_value = {mod_top_reg, mod_mid_reg, mod_lo_reg};
  wire [20:0] rdiv_ratio = plus_one(rdiv_value);
  wire [20:0] nint_ratio = plus_one({3'h0, nint_value});

  // Configuration outputs registered so they come straight from flops
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      high_margin_filter <= 1'b0;
      bandwidth_scale_factor <= 17'h00000;
      reference_divide_ratio <= 21'h000001;
      reference_halver_enable <= 1'b0;
      feedback_integer_ratio <= 18'h00001;
      feedback_numerator <= 23'h000000;
      feedback_modulus <= 23'h000000;
    end else if (clk_en) begin
      high_margin_filter <= margin_reg;
      bandwidth_scale_factor <= {bw_top_reg, bw_mid_reg, bw_lo_reg};
      reference_divide_ratio <= rdiv_ratio;
      reference_halver_enable <= halver_reg;
      feedback_integer_ratio <= nint_ratio[17:0];
      feedback_numerator <= frac_value;
      feedback_modulus <= mod_value;
    end
  end

  // Pin synchronisers; the first stage feeds only the second
  reg [1:0] present_sync;
  reg [1:0] ref_sync;
  reg [1:0] fb_sync;
  reg ref_last;
  reg fb_last;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      present_sync <= 2'b00;
      ref_sync <= 2'b00;
      fb_sync <= 2'b00;
      ref_last <= 1'b0;
      fb_last <= 1'b0;
    end else if (clk_en) begin
      present_sync <= {present_sync[0], reference_present};
      ref_sync <= {ref_sync[0], first_reference_input};
      fb_sync <= {fb_sync[0], feedback_input};
      ref_last <= ref_sync[1];
      fb_last <= fb_sync[1];
    end
  end

  // Rising edge of a synchronised pin against its level one cycle earlier
  function rising;
    input now_level;
    input last_level;
    begin
      rising = now_level & ~last_level;
    end
  endfunction

  wire ref_rise = rising(ref_sync[1], ref_last);
  wire fb_rise = rising(fb_sync[1], fb_last);

  // Validation timer: any dropout restarts the whole wait
  // Once valid, a longer time written later does not clear valid
  reg [31:0] ms_prescale;
  reg [15:0] ms_elapsed;
  wire ms_tick = (ms_prescale == CYCLES_PER_MS - 1);
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ms_prescale <= 32'h00000000;
      ms_elapsed <= 16'h0000;
      reference_valid <= 1'b0;
    end else if (clk_en) begin
      if (!present_sync[1]) begin
        ms_prescale <= 32'h00000000;
        ms_elapsed <= 16'h0000;
        reference_valid <= 1'b0;
      end else if (ms_elapsed >= valid_time) begin
        reference_valid <= 1'b1;
      end else begin
        ms_prescale <= ms_tick ? 32'h00000000 : ms_prescale + 32'h00000001;
        if (ms_tick) begin
          ms_elapsed <= ms_elapsed + 16'h0001;
        end
      end
    end
  end

  // Reference path: optional halver then divide by value plus one
  // Halver phase clears on each reference edge while bypassed, so enabling it starts a fresh pair
  reg halver_phase;
  reg [19:0] rdiv_count;
  wire ref_edge = ref_rise & (~halver_reg | halver_phase);
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      halver_phase <= 1'b0;
      rdiv_count <= 20'h00000;
      phase_detector_tick <= 1'b0;
    end else if (clk_en) begin
      phase_detector_tick <= 1'b0;
      if (ref_rise) begin
        halver_phase <= ~halver_phase & halver_reg;
      end
      if (ref_edge) begin
        if (rdiv_count >= rdiv_value) begin
          rdiv_count <= 20'h00000;
          phase_detector_tick <= 1'b1;
        end else begin
          rdiv_count <= rdiv_count + 20'h00001;
        end
      end
    end
  end

  // Feedback path: sigma-delta style first-order accumulator stretches
  // one cycle out of N+1 by an extra edge whenever the fraction overflows.
  // A zero modulus disables the fraction to avoid dividing by nothing.
  // A numerator at or above the modulus is outside the contract; the sum then holds or climbs.
  reg [17:0] fb_count;
  reg [23:0] frac_acc;
  reg extra_edge;
  wire [23:0] acc_sum = frac_acc + {1'b0, frac_value};
  wire frac_over = (mod_value != 23'h000000) && (acc_sum >= {1'b0, mod_value});
  wire [17:0] fb_limit = {1'b0, nint_value} + {17'h00000, extra_edge};
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fb_count <= 18'h00000;
      frac_acc <= 24'h000000;
      extra_edge <= 1'b0;
      feedback_tick <= 1'b0;
    end else if (clk_en) begin
      feedback_tick <= 1'b0;
      if (fb_rise) begin
        if (fb_count >= fb_limit) begin
          fb_count <= 18'h00000;
          feedback_tick <= 1'b1;
          extra_edge <= frac_over;
          if (mod_value == 23'h000000) begin
            frac_acc <= 24'h000000;
          end else if (frac_over) begin
            frac_acc <= acc_sum - {1'b0, mod_value};
          end else begin
            frac_acc <= acc_sum;
          end
        end else begin
          fb_count <= fb_count + 18'h00001;
        end
      end
    end
  end

endmodule // dpll_reference_profile_regs

// ===== verification/dpll_profile_props.sv
`timescale 1ns/100ps
`include "dpll_profile_consts.vh"
module dpll_profile_props (
  input wire clk,
  input wire sys_rst,
  input wire clk_en,
  input wire [13:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire reference_present,
  input wire reference_valid,
  input wire high_margin_filter,
  input wire [16:0] bandwidth_scale_factor,
  input wire [20:0] reference_divide_ratio,
  input wire reference_halver_enable,
  input wire [17:0] feedback_integer_ratio,
  input wire [22:0] feedback_numerator
);
  wire wr_ok = write && waitrequest && clk_en && byteenable[0] && address[1:0] == 2'b00;
  wire [11:0] idx = address[13:2];
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_wait_answer: assert property ((read || write) && waitrequest && clk_en |=> !waitrequest)
    else $error("request not answered next cycle");
  chk_wait_pulse: assert property (!waitrequest && clk_en |=> waitrequest)
    else $error("waitrequest low too long");
  chk_read_pad: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
    else $error("readdata upper bits set");
  // Config outputs lag the register by one cycle, so look two edges on
  chk_margin_bit: assert property (wr_ok && idx == `IDX_MARGIN |=> ##1
    high_margin_filter == $past(writedata[0], 2)) else $error("margin select wrong");
  chk_bw_top: assert property (wr_ok && idx == `IDX_BW_TOP |=> ##1
    bandwidth_scale_factor[16] == $past(writedata[0], 2)) else $error("bandwidth bit 16 wrong");
  chk_halver_bit: assert property (wr_ok && idx == `IDX_RDIV_TOP |=> ##1
    reference_halver_enable == $past(writedata[4], 2)) else $error("halver enable wrong");
  chk_frac_top: assert property (wr_ok && idx == `IDX_FRAC_TOP |=> ##1
    feedback_numerator[22:16] == $past(writedata[6:0], 2)) else $error("numerator top wrong");
  chk_ratio_floor: assert property (reference_divide_ratio != 0
    && feedback_integer_ratio != 0) else $error("divide ratio zero");
  chk_valid_drop: assert property (!reference_present [*5] |-> !reference_valid)
    else $error("valid without reference");
  chk_freeze_state: assert property (!clk_en |=> $stable(waitrequest) && $stable(reference_valid)
    && $stable(high_margin_filter) && $stable(bandwidth_scale_factor))
    else $error("state moved while clock enable low");
endmodule // dpll_profile_props
bind dpll_reference_profile_regs dpll_profile_props chk (.clk(clk), .sys_rst(sys_rst),
  .clk_en(clk_en), .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .reference_present(reference_present), .reference_valid(reference_valid),
  .high_margin_filter(high_margin_filter), .bandwidth_scale_factor(bandwidth_scale_factor),
  .reference_divide_ratio(reference_divide_ratio),
  .reference_halver_enable(reference_halver_enable),
  .feedback_integer_ratio(feedback_integer_ratio), .feedback_numerator(feedback_numerator));

// ===== verification/dpll_reference_profile_regs_bench.sv
`timescale 1ns/100ps
`include "dpll_profile_consts.vh"
module dpll_reference_profile_regs_bench;
  reg clk = 0, sys_rst = 1, read = 0, write = 0, present = 0, ref_in = 0, fb_in = 0;
  reg clk_en = 1;
  reg [13:0] address = 0;
  reg [31:0] writedata = 0;
  reg [3:0] byteenable = 4'hf;
  reg [127:0] img = 128'h0000_0400_076b_0000_c500_01f4_0000_000a;
  reg [7:0] rd, d;
  reg [31:0] r;
  wire [31:0] readdata;
  wire waitrequest, valid, margin, halver, pd_tick, fb_tick;
  wire [16:0] bw;
  wire [20:0] rdiv;
  wire [17:0] nint;
  wire [22:0] num;
  wire [22:0] modl;
  integer n_mismatch = 0, checks = 0, n_pd = 0, n_fb = 0, p0, f0, i;
  dpll_reference_profile_regs #(.CYCLES_PER_MS(4)) DUT (.clk(clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .reference_present(present), .first_reference_input(ref_in), .feedback_input(fb_in),
    .reference_valid(valid), .high_margin_filter(margin), .bandwidth_scale_factor(bw),
    .reference_divide_ratio(rdiv), .reference_halver_enable(halver),
    .feedback_integer_ratio(nint), .feedback_numerator(num), .feedback_modulus(modl),
    .phase_detector_tick(pd_tick), .feedback_tick(fb_tick));
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    n_pd <= n_pd + pd_tick;
    n_fb <= n_fb + fb_tick;
  end
  function [7:0] rmask(input [3:0] k);
    case (k)
      2: rmask = 8'h00;
      3, 6, 12: rmask = 8'h01;
      9: rmask = 8'h1f;
      15: rmask = 8'h7f;
      default: rmask = 8'hff;
    endcase
  endfunction
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task bus(input wr, input [11:0] idx, input [7:0] wd);
    begin
      @(posedge clk);
      read <= !wr;
      write <= wr;
      address <= {idx, 2'b00};
      writedata <= {24'h0, wd};
      do begin
        @(posedge clk);
      end while (waitrequest !== 1'b0);
      rd = readdata[7:0];
      cmp(readdata[31:8], 24'h000000);
      read <= 0;
      write <= 0;
    end
  endtask
  task wr(input [3:0] k, input [7:0] v);
    begin
      bus(1, 12'h70b + k, v);
      img[8*k +: 8] = v & rmask(k);
    end
  endtask
  task rdk(input [3:0] k);
    begin
      bus(0, 12'h70b + k, 0);
      cmp(rd, img[8*k +: 8]);
    end
  endtask
  task outs;
    begin
      wt(2);
      cmp(margin, img[24]);
      cmp(bw, {img[48], img[47:32]});
      cmp(rdiv, {img[75:72], img[71:56]} + 1);
      cmp(halver, img[76]);
      cmp(nint, {img[96], img[95:80]} + 1);
      cmp(num, img[126:104]);
    end
  endtask
  // Pins toggle every four clocks: the edge detector needs each level held a clock, so slower than clk/2
  task edges(input integer n);
    repeat (2 * n) begin
      wt(4);
      ref_in <= ~ref_in;
      fb_in <= ~fb_in;
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    wt(20000);
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
  initial begin
    void'($urandom(93643));
    wt(8);
    sys_rst <= 0;
    for (i = 0; i < 16; i = i + 1) rdk(i);
    outs;
    cmp(modl, {`RST_MOD_TOP, `RST_MOD_MID, `RST_MOD_LO});
    bus(0, 12'h700, 0);
    cmp(rd, 0);
    wr(7, 8'h02);
    wr(10, 8'h03);
    wr(11, 8'h00);
    bus(1, `IDX_MOD_LO, 8'h00);
    // 50 Hz bandwidth, normal margin and a short reference divider stay within use limits
    edges(24);
    wt(8);
    cmp(n_pd, 8);
    cmp(n_fb, 6);
    // Numerator 1 over modulus 2 makes the feedback ratio alternate 4 and 5
    wr(9, 8'h10);
    wr(13, 8'h01);
    bus(1, `IDX_MOD_LO, 8'h02);
    p0 = n_pd;
    f0 = n_fb;
    edges(36);
    wt(8);
    cmp(n_pd - p0, 6);
    cmp(n_fb - f0, 8);
    cmp(modl, 2);
    wr(0, 8'h03);
    wr(1, 8'h00);
    present <= 1;
    wt(8);
    cmp(valid, 0);
    wt(16);
    cmp(valid, 1);
    bus(0, `IDX_STATUS, 0);
    cmp(rd, {6'h00, img[76], 1'b1});
    present <= 0;
    wt(6);
    cmp(valid, 0);
    for (i = 0; i < 48; i = i + 1) begin
      r = $urandom;
      d = i < 16 ? 8'hff : r[7:0];
      wr(i % 16, d);
      rdk(i % 16);
      if (i % 16 == 15) outs;
    end
    // Clock enable low stalls a write: no answer and no register change
    clk_en <= 0;
    fork
      wr(3, ~img[31:24]);
      begin
        wt(6);
        cmp(waitrequest, 1);
        cmp(margin, img[24]);
        clk_en <= 1;
      end
    join
    outs;
    byteenable <= 4'he;
    bus(1, `IDX_MARGIN, ~img[31:24]);
    byteenable <= 4'hf;
    rdk(3);
    bus(1, 12'h700, 8'hff);
    bus(0, 12'h700, 0);
    cmp(rd, 0);
    complete_run;
  end
endmodule // dpll_reference_profile_regs_bench
